// [logic/trigger_input_debounce_filter.sv]
`timescale 1ns/1ps
`include "trig_filter_defs.svh"

module trigger_input_debounce_filter #(
	parameter int unsigned NUM_FT = `TF_NUM_FT,
	parameter int unsigned NUM_ITL = `TF_NUM_ITL,
	parameter int unsigned N_LONG = `TF_N_LONG,
	localparam int unsigned NUM_IN = NUM_FT + NUM_ITL + 1,
	localparam int unsigned FT_SEL_W = (NUM_FT > 1) ? $clog2(NUM_FT) : 1,
	localparam int unsigned ITL_SEL_W = $clog2(NUM_ITL),
	localparam int unsigned IN_SEL_W = $clog2(NUM_IN)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Trigger pins, receive side; the star line has no driver here
	input wire logic [NUM_FT-1:0] function_terminal_in,
	input wire logic [NUM_ITL-1:0] intermodule_trigger_line_in,
	input wire logic star_in,
	// Filter configuration, one input per write
	input wire trig_filter_pkg::cfg_wr_s cfg_wr,
	// Direct routes between terminals and lines, both directions
	input wire logic [NUM_ITL-1:0] itl_route_en,
	input wire logic [NUM_ITL-1:0][FT_SEL_W-1:0] itl_route_src,
	input wire logic [NUM_FT-1:0] ft_route_en,
	input wire logic [NUM_FT-1:0][ITL_SEL_W-1:0] ft_route_src,
	// Trigger pins, drive side
	output logic [NUM_ITL-1:0] intermodule_trigger_line_out,
	output logic [NUM_ITL-1:0] intermodule_trigger_line_oe,
	output logic [NUM_FT-1:0] function_terminal_out,
	output logic [NUM_FT-1:0] function_terminal_oe,
	// Qualified levels: terminals, then lines, then star on top
	output logic [NUM_IN-1:0] filtered_level,
	// Outside timing source per consumer
	input wire logic [`TF_NUM_CONS-1:0][IN_SEL_W-1:0] ext_src_sel,
	output logic [`TF_NUM_CONS-1:0] ext_src
);

	localparam int unsigned STAR_IDX = NUM_FT + NUM_ITL;
	localparam logic [`TF_ACC_W-1:0] ACC_STEP = `TF_ACC_W'(`TF_FILT_CLK_KHZ);
	localparam logic [`TF_ACC_W-1:0] ACC_WRAP =
		`TF_ACC_W'(`TF_SYS_CLK_KHZ - `TF_FILT_CLK_KHZ);

	// Chassis bus has exactly eight lines mapped onto 0..7
	if (NUM_ITL != 8 || NUM_FT < 1 || NUM_IN > 32) begin : g_chk
		$error("trigger_input_debounce_filter: unsupported input counts");
	end

	logic [NUM_IN-1:0] raw;
	logic [NUM_IN-1:0] sync1;
	logic [NUM_IN-1:0] sync2;
	logic [NUM_IN-1:0] sync3;
	logic [NUM_IN-1:0] stable;
	logic [`TF_ACC_W-1:0] frac_acc;
	logic filt_tick;
	trig_filter_pkg::filter_setting_e setting [NUM_IN];

	// Star is input only; nothing in this block can drive it
	assign raw = {star_in, intermodule_trigger_line_in,
		function_terminal_in};

	// Three-stage synchroniser; a change counts when stages 2 and 3 agree
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			stable <= '0;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
			sync3 <= sync2;
			stable <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & stable);
		end
	end

	// Fractional divider: 40 ticks per 125 clocks, no outside reference
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			frac_acc <= '0;
			filt_tick <= 1'b0;
		end else if (frac_acc >= ACC_WRAP) begin
			frac_acc <= frac_acc - ACC_WRAP;
			filt_tick <= 1'b1;
		end else begin
			frac_acc <= frac_acc + ACC_STEP;
			filt_tick <= 1'b0;
		end
	end

	// One setting register and one filter per input
	for (genvar i = 0; i < NUM_IN; i++) begin : g_in
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				setting[i] <= trig_filter_pkg::FILT_OFF;
			end else if (cfg_wr.valid && cfg_wr.index == 5'(i)) begin
				setting[i] <= cfg_wr.setting;
			end
		end

		debounce_cell #(
			.N_SHORT(`TF_N_SHORT),
			.N_MID(`TF_N_MID),
			.N_LONG(N_LONG),
			.CNT_W(`TF_CNT_W)
		) debounce_cell_inst (
			.sys_clk(sys_clk),
			.nrst(nrst),
			.sample_en(filt_tick),
			.level_in(stable[i]),
			.setting(setting[i]),
			.level_out(filtered_level[i])
		);

		property p_setting_isolated;
			@(posedge sys_clk) disable iff (!nrst)
			!(cfg_wr.valid && cfg_wr.index == 5'(i)) |=> $stable(setting[i]);
		endproperty
		a_setting_isolated: assert property (p_setting_isolated)
			else $error("setting changed without a write to its input");
	end

	// Direct routes take the synchronised level, never the filtered one
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			intermodule_trigger_line_out <= '0;
			intermodule_trigger_line_oe <= '0;
			function_terminal_out <= '0;
			function_terminal_oe <= '0;
		end else begin
			intermodule_trigger_line_oe <= itl_route_en;
			function_terminal_oe <= ft_route_en;
			for (int j = 0; j < NUM_ITL; j++) begin
				intermodule_trigger_line_out[j] <=
					(int'(itl_route_src[j]) < NUM_FT) &&
					stable[itl_route_src[j]];
			end
			for (int k = 0; k < NUM_FT; k++) begin
				function_terminal_out[k] <=
					stable[NUM_FT + int'(ft_route_src[k])];
			end
		end
	end

	// Consumer source mux; out-of-range picks read low
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ext_src <= '0;
		end else begin
			for (int c = 0; c < `TF_NUM_CONS; c++) begin
				ext_src[c] <= (int'(ext_src_sel[c]) < NUM_IN) &&
					filtered_level[ext_src_sel[c]];
			end
		end
	end

	property p_tick_spacing;
		@(posedge sys_clk) disable iff (!nrst)
		filt_tick |=> !filt_tick [*2];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("filter tick faster than 40 MHz");

	property p_route_unfiltered;
		@(posedge sys_clk) disable iff (!nrst)
		(itl_route_en[0] && itl_route_src[0] == '0 &&
			function_terminal_in[0]) [*7]
			|=> intermodule_trigger_line_out[0] && intermodule_trigger_line_oe[0];
	endproperty
	a_route_unfiltered: assert property (p_route_unfiltered)
		else $error("direct route did not forward the raw terminal");

	property p_star_source;
		@(posedge sys_clk) disable iff (!nrst)
		(ext_src_sel[`TF_CONS_AI] == IN_SEL_W'(STAR_IDX) &&
			filtered_level[STAR_IDX]) |=> ext_src[`TF_CONS_AI];
	endproperty
	a_star_source: assert property (p_star_source)
		else $error("star trigger not delivered to analog input");

endmodule : trigger_input_debounce_filter

// [shared/trig_filter_defs.svh]
// Behaviour
// - Every terminal, line and star input has its own switchable filter.
// - An enabled filter samples its input only on filter clock rising edges.
// - The filter clock is 40 MHz, from the board clock, not an outside one.
// - A rise passes inward only after N consecutive high samples.
// - A fall passes inward only after N consecutive low samples.
// - The setting picks N = 5, 257, about 101,800, or no filtering.
// - Each input has its own setting; a write leaves all others unchanged.
// - Power-up reset disables every filter, so raw inputs pass straight on.
// - Direct routes between terminals and lines carry the unfiltered input.
// - The eight bused chassis trigger lines are intermodule lines 0 to 7.
// - The star trigger is only received, never driven.
// - The star trigger can source analog in, analog out and counter timing.
`ifndef TRIG_FILTER_DEFS_SVH
`define TRIG_FILTER_DEFS_SVH

// Clock rates in kHz
`define TF_SYS_CLK_KHZ 125000
`define TF_FILT_CLK_KHZ 40000
`define TF_ACC_W 17

// Consecutive samples needed per setting
`define TF_N_SHORT 5
`define TF_N_MID 257
`define TF_N_LONG 101800
`define TF_CNT_W 17

// Input counts
`define TF_NUM_FT 6
`define TF_NUM_ITL 8
`define TF_IDX_W 5

// Consumers of outside timing sources
`define TF_CONS_AI 0
`define TF_CONS_AO 1
`define TF_CONS_CTR 2
`define TF_NUM_CONS 3

`endif

// [shared/trig_filter_pkg.sv]
package trig_filter_pkg;

	// Filter choice per input; the first value is the reset state
	typedef enum logic [1:0] {
		FILT_OFF,
		FILT_SHORT,
		FILT_MID,
		FILT_LONG
	} filter_setting_e;

	// One configuration write for one input
	typedef struct packed {
		logic valid;
		logic [4:0] index;
		filter_setting_e setting;
	} cfg_wr_s;

endpackage : trig_filter_pkg

// [logic/debounce_cell.sv]
`timescale 1ns/1ps
`include "trig_filter_defs.svh"

module debounce_cell #(
	parameter int unsigned N_SHORT = `TF_N_SHORT,
	parameter int unsigned N_MID = `TF_N_MID,
	parameter int unsigned N_LONG = `TF_N_LONG,
	parameter int unsigned CNT_W = `TF_CNT_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Sample strobe and synchronised level
	input wire logic sample_en,
	input wire logic level_in,
	input wire trig_filter_pkg::filter_setting_e setting,
	// Qualified level
	output logic level_out
);

	if (N_SHORT < 1 || N_MID < 1 || N_LONG < 1 ||
		N_LONG >= (64'd1 << CNT_W)) begin : g_chk
		$error("debounce_cell: sample counts do not fit the counter");
	end

	logic [CNT_W-1:0] n_req;
	logic [CNT_W-1:0] run;
	logic [CNT_W-1:0] hi_run;
	logic [CNT_W-1:0] lo_run;

	// Required match count for the current setting
	always_comb begin
		unique case (setting)
			trig_filter_pkg::FILT_OFF: n_req = CNT_W'(1);
			trig_filter_pkg::FILT_SHORT: n_req = CNT_W'(N_SHORT);
			trig_filter_pkg::FILT_MID: n_req = CNT_W'(N_MID);
			trig_filter_pkg::FILT_LONG: n_req = CNT_W'(N_LONG);
		endcase
	end

	// Count disagreeing samples; >= covers a switch to a shorter setting
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			level_out <= 1'b0;
			run <= '0;
		end else if (setting == trig_filter_pkg::FILT_OFF) begin
			level_out <= level_in;
			run <= '0;
		end else if (sample_en) begin
			if (level_in == level_out) begin
				run <= '0;
			end else if (run >= n_req - CNT_W'(1)) begin
				level_out <= level_in;
				run <= '0;
			end else begin
				run <= run + CNT_W'(1);
			end
		end
	end

	// Consecutive same-level samples, watched by the checks below
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hi_run <= '0;
			lo_run <= '0;
		end else if (setting == trig_filter_pkg::FILT_OFF) begin
			hi_run <= '0;
			lo_run <= '0;
		end else if (sample_en) begin
			hi_run <= level_in ? hi_run + CNT_W'(hi_run != '1) : '0;
			lo_run <= level_in ? '0 : lo_run + CNT_W'(lo_run != '1);
		end
	end

	property p_tick_only;
		@(posedge sys_clk) disable iff (!nrst)
		(setting != trig_filter_pkg::FILT_OFF && !sample_en)
			|=> $stable(level_out);
	endproperty
	a_tick_only: assert property (p_tick_only)
		else $error("filtered level moved between filter ticks");

	property p_rise_needs_n;
		@(posedge sys_clk) disable iff (!nrst)
		(setting != trig_filter_pkg::FILT_OFF && sample_en && level_in &&
			!level_out && hi_run < n_req - CNT_W'(1)) |=> !level_out;
	endproperty
	a_rise_needs_n: assert property (p_rise_needs_n)
		else $error("filtered level rose before N high samples");

	property p_fall_needs_n;
		@(posedge sys_clk) disable iff (!nrst)
		(setting != trig_filter_pkg::FILT_OFF && sample_en && !level_in &&
			level_out && lo_run < n_req - CNT_W'(1)) |=> level_out;
	endproperty
	a_fall_needs_n: assert property (p_fall_needs_n)
		else $error("filtered level fell before N low samples");

	property p_rise_at_n;
		@(posedge sys_clk) disable iff (!nrst)
		(setting != trig_filter_pkg::FILT_OFF && sample_en && level_in &&
			!level_out && hi_run >= n_req - CNT_W'(1)) |=> level_out;
	endproperty
	a_rise_at_n: assert property (p_rise_at_n)
		else $error("filtered level missed its N-th high sample");

	property p_enable_clean;
		@(posedge sys_clk) disable iff (!nrst)
		(setting == trig_filter_pkg::FILT_OFF ##1
			setting != trig_filter_pkg::FILT_OFF) |-> level_out == $past(level_in);
	endproperty
	a_enable_clean: assert property (p_enable_clean)
		else $error("filter enabled from a stale level");

endmodule : debounce_cell

// [verif/trig_source.sv]
`timescale 1ns/1ps

module trig_source (
	// Device drive side
	input wire logic [7:0] line_out,
	input wire logic [7:0] line_oe,
	input wire logic [5:0] term_out,
	input wire logic [5:0] term_oe,
	// Levels seen at the device pins
	output logic [5:0] function_terminal_in,
	output logic [7:0] intermodule_trigger_line_in,
	output logic star_in
);
	// Outside source levels: terminals, lines, star on top
	logic [14:0] lvl = '0;

	// Shared wires: the device wins wherever it drives
	assign function_terminal_in = term_oe & term_out | ~term_oe & lvl[5:0];
	assign intermodule_trigger_line_in =
		line_oe & line_out | ~line_oe & lvl[13:6];
	assign star_in = lvl[14];

	// Sources change level only when the bench asks
	task automatic set(input int idx, input logic v);
		lvl[idx] = v;
	endtask : set
endmodule : trig_source

// [verif/trigger_input_debounce_filter_tb.sv]
`timescale 1ns/1ps

module trigger_input_debounce_filter_tb;
	localparam int NL = 20;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [5:0] ft_in, ft_out, ft_oe;
	logic [7:0] itl_in, itl_out, itl_oe;
	logic star_in;
	trig_filter_pkg::cfg_wr_s cfg_wr = '0;
	logic [7:0] itl_en = '0;
	logic [7:0][2:0] itl_src = '0;
	logic [5:0] ft_en = '0;
	logic [5:0][2:0] ft_src = '0;
	logic [14:0] filt;
	logic [2:0][3:0] sel = '0;
	logic [2:0] ext;
	int mismatches = 0;
	int compares = 0;

	// Free-running system clock
	always #4 sys_clk = ~sys_clk;

	// Device with a short long-setting count to keep the run brief
	trigger_input_debounce_filter #(.N_LONG(NL))
		trigger_input_debounce_filter_inst (.sys_clk(sys_clk), .nrst(nrst),
		.function_terminal_in(ft_in), .intermodule_trigger_line_in(itl_in),
		.star_in(star_in), .cfg_wr(cfg_wr), .itl_route_en(itl_en),
		.itl_route_src(itl_src), .ft_route_en(ft_en),
		.ft_route_src(ft_src), .intermodule_trigger_line_out(itl_out),
		.intermodule_trigger_line_oe(itl_oe), .function_terminal_out(ft_out),
		.function_terminal_oe(ft_oe), .filtered_level(filt),
		.ext_src_sel(sel), .ext_src(ext));

	// Outside trigger sources
	trig_source trig_source_inst (.line_out(itl_out), .line_oe(itl_oe),
		.term_out(ft_out), .term_oe(ft_oe), .function_terminal_in(ft_in),
		.intermodule_trigger_line_in(itl_in), .star_in(star_in));

	task automatic close_out;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	task automatic chk_bit(input logic got, input logic exp, string m);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk_bit

	task automatic chk_rng(input int n, input int lo, input int hi, string m);
		compares++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("ERROR %0t %s took %0d", $time, m, n);
		end
	endtask : chk_rng

	// Bounded wait for one qualified level
	task automatic wait_lvl(input int i, input logic v, input int lim,
		output int n);
		n = 0;
		while (filt[i] !== v) begin
			@(negedge sys_clk);
			n++;
			if (n > lim) begin
				mismatches++;
				$display("ERROR %0t level wait ran out", $time);
				close_out();
			end
		end
	endtask : wait_lvl

	// One write; caller clears valid after the last of a burst
	task automatic cfg(input int i, trig_filter_pkg::filter_setting_e s);
		cfg_wr = '{valid: 1'b1, index: 5'(i), setting: s};
		@(negedge sys_clk);
	endtask : cfg

	// Rise and fall latency for one setting; zero count means unfiltered
	task automatic t_filter(input int i,
		trig_filter_pkg::filter_setting_e s, input int n);
		int c;
		int lo;
		int hi;
		// Five-clock input pipeline, then N ticks three or four clocks apart
		lo = n ? 3 * n + 2 : 4;
		hi = n ? 3 * n + n / 8 + 12 : 6;
		if (n) begin
			cfg(i, s);
			cfg_wr = '0;
		end
		repeat (4) @(negedge sys_clk);
		trig_source_inst.set(i, 1'b1);
		wait_lvl(i, 1'b1, hi, c);
		chk_rng(c, lo, hi, "rise");
		trig_source_inst.set(i, 1'b0);
		wait_lvl(i, 1'b0, hi, c);
		chk_rng(c, lo, hi, "fall");
	endtask : t_filter

	// Pulses of eight clocks hold at most three ticks, never five
	task automatic t_glitch;
		logic seen;
		seen = 1'b0;
		cfg(11, trig_filter_pkg::FILT_SHORT);
		cfg_wr = '0;
		for (int k = 0; k < 40; k++) begin
			trig_source_inst.set(11, k < 24 && k % 12 < 8);
			@(negedge sys_clk);
			seen = seen | filt[11];
		end
		chk_bit(seen, 1'b0, "glitch passed");
	endtask : t_glitch

	// Back-to-back writes touch only their own input
	task automatic t_indep;
		cfg(2, trig_filter_pkg::FILT_SHORT);
		cfg(3, trig_filter_pkg::FILT_OFF);
		cfg_wr = '0;
		trig_source_inst.set(2, 1'b1);
		trig_source_inst.set(3, 1'b1);
		repeat (7) @(negedge sys_clk);
		chk_bit(filt[3], 1'b1, "unfiltered lagged");
		chk_bit(filt[2], 1'b0, "filter too fast");
	endtask : t_indep

	// Enabling under a high level must not drop the output
	task automatic t_enable_hi;
		int c;
		logic low_seen;
		low_seen = 1'b0;
		trig_source_inst.set(4, 1'b1);
		wait_lvl(4, 1'b1, 8, c);
		cfg(4, trig_filter_pkg::FILT_SHORT);
		cfg_wr = '0;
		repeat (30) begin
			@(negedge sys_clk);
			low_seen = low_seen | ~filt[4];
		end
		chk_bit(low_seen, 1'b0, "false edge on enable");
	endtask : t_enable_hi

	// Star as outside source for all three consumers
	task automatic t_star;
		int c;
		sel = {3{4'he}};
		cfg(14, trig_filter_pkg::FILT_SHORT);
		cfg_wr = '0;
		chk_bit(|ext, 1'b0, "consumer idle");
		trig_source_inst.set(14, 1'b1);
		wait_lvl(14, 1'b1, 30, c);
		chk_rng(c, 17, 27, "star rise");
		@(negedge sys_clk);
		chk_bit(&ext, 1'b1, "consumer select");
	endtask : t_star

	// Direct routes skip the slow filter in both directions
	task automatic t_route;
		cfg(0, trig_filter_pkg::FILT_LONG);
		cfg(7, trig_filter_pkg::FILT_LONG);
		cfg_wr = '0;
		itl_en[0] = 1'b1;
		ft_src[1] = 3'h1;
		ft_en[1] = 1'b1;
		trig_source_inst.set(0, 1'b1);
		trig_source_inst.set(7, 1'b1);
		repeat (10) @(negedge sys_clk);
		chk_bit(itl_oe[0] & ft_oe[1], 1'b1, "route enable");
		chk_bit(itl_out[0] & ft_out[1], 1'b1, "route data");
		chk_bit(filt[0] | filt[7], 1'b0, "filter bypassed");
	endtask : t_route

	// Main sequence
	initial begin
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (3) @(negedge sys_clk);
		t_filter(1, trig_filter_pkg::FILT_OFF, 0);
		t_filter(8, trig_filter_pkg::FILT_SHORT, 5);
		t_filter(9, trig_filter_pkg::FILT_MID, 257);
		t_filter(10, trig_filter_pkg::FILT_LONG, NL);
		t_glitch();
		t_indep();
		t_enable_hi();
		t_star();
		t_route();
		close_out();
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		$display("ERROR %0t run limit reached", $time);
		close_out();
	end
endmodule : trigger_input_debounce_filter_tb
